// >>> src/bal_pkg.sv
// Package: opcodes, flag positions and timing for the byte ALU
package bal_pkg;
    localparam int OP_W = 5;
    localparam logic [4:0] OP_ADD_REG = 5'h00;
    localparam logic [4:0] OP_ADD_CARRY_REG = 5'h01;
    localparam logic [4:0] OP_WORD_ADD_IMM = 5'h02;
    localparam logic [4:0] OP_SUB_REG = 5'h03;
    localparam logic [4:0] OP_SUB_IMM = 5'h04;
    localparam logic [4:0] OP_SUB_CARRY_REG = 5'h05;
    localparam logic [4:0] OP_SUB_CARRY_IMM = 5'h06;
    localparam logic [4:0] OP_WORD_SUB_IMM = 5'h07;
    localparam logic [4:0] OP_AND_REG = 5'h08;
    localparam logic [4:0] OP_AND_IMM = 5'h09;
    localparam logic [4:0] OP_OR_REG = 5'h0A;
    localparam logic [4:0] OP_OR_IMM = 5'h0B;
    localparam logic [4:0] OP_XOR_REG = 5'h0C;
    localparam logic [4:0] OP_SET_BITS = 5'h0D;
    localparam logic [4:0] OP_CLEAR_BITS = 5'h0E;
    localparam logic [4:0] OP_TEST_VALUE = 5'h0F;
    localparam logic [4:0] OP_ZERO_REG = 5'h10;
    localparam logic [4:0] OP_INCREMENT = 5'h11;
    localparam logic [4:0] OP_DECREMENT = 5'h12;
    // Flag bit positions in the status byte
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] ALL_ONES = 8'hFF;
    localparam logic [7:0] MASK_ARITH = 8'h2F;
    localparam logic [7:0] MASK_WORD = 8'h1F;
    localparam logic [7:0] MASK_LOGIC = 8'h0E;
    localparam int BYTE_CYCLES = 1;
    localparam int WORD_CYCLES = 2;
endpackage : bal_pkg

// >>> src/bal_word_if.sv
// Interface carrying a word operation from the ALU to its word stage
interface bal_word_if;
    logic start;
    logic sub;
    logic [15:0] value;
    logic [7:0] imm;
    logic done;
    logic [15:0] result;
    logic [7:0] flags;
    modport alu (output start, output sub, output value, output imm,
                 input done, input result, input flags);
    modport stage (input start, input sub, input value, input imm,
                   output done, output result, output flags);
endinterface : bal_word_if

// >>> src/bal_word_stage.sv
// Two-cycle 16-bit add or subtract of an immediate on a register pair
module bal_word_stage (
    input wire logic clk,
    input wire logic rst_n,
    bal_word_if.stage wif
);
    typedef struct packed {
        logic busy;
        logic sub;
        logic [16:0] low;
        logic [15:0] value;
        logic done;
        logic [15:0] result;
        logic [7:0] flags;
    } bal_ws_t;

    bal_ws_t st_ff;
    bal_ws_t nxt_st;

    // Low byte in the first cycle, high byte and flags in the second,
    // which keeps the carry chain to eight bits per cycle.
    always_comb begin
        logic [8:0] hi;
        logic [15:0] r;
        hi = 9'h000;
        r = 16'h0000;
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        if (wif.start && !st_ff.busy) begin
            nxt_st.busy = 1'b1;
            nxt_st.sub = wif.sub;
            nxt_st.value = wif.value;
            if (wif.sub) begin
                nxt_st.low = {9'h000, wif.value[7:0]} - {9'h000, wif.imm};
            end else begin
                nxt_st.low = {9'h000, wif.value[7:0]} + {9'h000, wif.imm};
            end
        end else if (st_ff.busy) begin
            if (st_ff.sub) begin
                hi = {1'b0, st_ff.value[15:8]} - {8'h00, st_ff.low[8]};
            end else begin
                hi = {1'b0, st_ff.value[15:8]} + {8'h00, st_ff.low[8]};
            end
            r = {hi[7:0], st_ff.low[7:0]};
            nxt_st.busy = 1'b0;
            nxt_st.done = 1'b1;
            nxt_st.result = r;
            nxt_st.flags = 8'h00;
            nxt_st.flags[bal_pkg::FLAG_Z] = (r == 16'h0000);
            nxt_st.flags[bal_pkg::FLAG_N] = r[15];
            if (st_ff.sub) begin
                nxt_st.flags[bal_pkg::FLAG_V] = st_ff.value[15] & ~r[15];
                nxt_st.flags[bal_pkg::FLAG_C] = r[15] & ~st_ff.value[15];
            end else begin
                nxt_st.flags[bal_pkg::FLAG_V] = ~st_ff.value[15] & r[15];
                nxt_st.flags[bal_pkg::FLAG_C] = ~r[15] & st_ff.value[15];
            end
            nxt_st.flags[bal_pkg::FLAG_S] = r[15] ^ nxt_st.flags[bal_pkg::FLAG_V];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign wif.done = st_ff.done;
    assign wif.result = st_ff.result;
    assign wif.flags = st_ff.flags;
endmodule : bal_word_stage

// >>> src/bal_alu.sv
// Byte arithmetic and logic datapath with status flag update

// Behaviour
// - Add two bytes, optionally plus carry; update Z C N V H in one cycle.
// - Word add of immediate to pair; update Z C N V S in three cycles.
// - Subtract register or immediate; update Z C N V H in one cycle.
// - Subtract operand and carry; update Z C N V H in one cycle.
// - Word subtract immediate from pair; update Z C N V S in three cycles.
// - AND with register or constant; update only Z N V, one cycle.
// - OR with register or constant; update only Z N V, one cycle.
// - Set bits ORs constant mask in; update Z N V, one cycle.
// - Clear bits ANDs with 0xFF minus mask; update Z N V, one cycle.
// - Test ANDs value with itself, writes back unchanged; Z N V, one cycle.
module bal_alu (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic op_valid,
    input wire logic [4:0] op_code,
    input wire logic [7:0] dest_operand,
    input wire logic [7:0] source_operand,
    input wire logic [7:0] pair_high,
    input wire logic [7:0] imm_value,
    input wire logic [7:0] flags_in,
    output logic busy,
    output logic res_valid,
    output logic res_word,
    output logic [7:0] res_low,
    output logic [7:0] res_high,
    output logic [7:0] flags_out,
    output logic [7:0] flags_mask
);
    typedef enum logic [1:0] {
        BAL_IDLE = 2'b01,
        BAL_WORD = 2'b10
    } bal_state_t;

    typedef struct packed {
        bal_state_t state;
        logic busy;
        logic res_valid;
        logic res_word;
        logic [7:0] res_low;
        logic [7:0] res_high;
        logic [7:0] flags_out;
        logic [7:0] flags_mask;
    } bal_alu_t;

    bal_alu_t st_ff;
    bal_alu_t nxt_st;
    bal_word_if wif ();

    bal_word_stage u_word (
        .clk(clk),
        .rst_n(rst_n),
        .wif(wif.stage)
    );

    // Byte add or subtract with carry in; returns {h, v, c, result}
    function automatic logic [10:0] bal_addsub(input logic [7:0] a, input logic [7:0] b,
                                               input logic cin, input logic sub);
        logic [8:0] s;
        logic [4:0] nib;
        logic h;
        logic v;
        logic c;
        if (sub) begin
            s = {1'b0, a} - {1'b0, b} - {8'h00, cin};
            nib = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
            v = (a[7] & ~b[7] & ~s[7]) | (~a[7] & b[7] & s[7]);
        end else begin
            s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
            nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
            v = (a[7] & b[7] & ~s[7]) | (~a[7] & ~b[7] & s[7]);
        end
        h = nib[4];
        c = s[8];
        return {h, v, c, s[7:0]};
    endfunction

    // Logic-class flags: Z and N from result, V cleared
    function automatic logic [7:0] bal_logic_flags(input logic [7:0] r);
        logic [7:0] f;
        f = 8'h00;
        f[bal_pkg::FLAG_Z] = (r == 8'h00);
        f[bal_pkg::FLAG_N] = r[7];
        return f;
    endfunction

    always_comb begin
        logic [10:0] ar;
        logic [7:0] lr;
        logic carry;
        logic arith;
        logic is_sub;
        logic use_carry;
        logic [7:0] operand;
        ar = 11'h000;
        lr = 8'h00;
        arith = 1'b0;
        is_sub = 1'b0;
        use_carry = 1'b0;
        operand = source_operand;
        carry = flags_in[bal_pkg::FLAG_C];
        nxt_st = st_ff;
        nxt_st.res_valid = 1'b0;
        wif.start = 1'b0;
        wif.sub = 1'b0;
        wif.value = {pair_high, dest_operand};
        wif.imm = imm_value;
        case (st_ff.state)
            BAL_IDLE: begin
                if (op_valid) begin
                    nxt_st.res_valid = 1'b1;
                    nxt_st.res_word = 1'b0;
                    nxt_st.res_high = 8'h00;
                    nxt_st.flags_mask = bal_pkg::MASK_LOGIC;
                    case (op_code)
                        bal_pkg::OP_ADD_REG: begin
                            arith = 1'b1;
                        end
                        bal_pkg::OP_ADD_CARRY_REG: begin
                            arith = 1'b1;
                            use_carry = 1'b1;
                        end
                        bal_pkg::OP_SUB_REG, bal_pkg::OP_SUB_IMM: begin
                            arith = 1'b1;
                            is_sub = 1'b1;
                            if (op_code == bal_pkg::OP_SUB_IMM) begin
                                operand = imm_value;
                            end
                        end
                        bal_pkg::OP_SUB_CARRY_REG, bal_pkg::OP_SUB_CARRY_IMM: begin
                            arith = 1'b1;
                            is_sub = 1'b1;
                            use_carry = 1'b1;
                            if (op_code == bal_pkg::OP_SUB_CARRY_IMM) begin
                                operand = imm_value;
                            end
                        end
                        bal_pkg::OP_WORD_ADD_IMM, bal_pkg::OP_WORD_SUB_IMM: begin
                            // Result is held back until the word stage finishes
                            nxt_st.res_valid = 1'b0;
                            nxt_st.busy = 1'b1;
                            nxt_st.state = BAL_WORD;
                            wif.start = 1'b1;
                            wif.sub = (op_code == bal_pkg::OP_WORD_SUB_IMM);
                        end
                        bal_pkg::OP_AND_REG: lr = dest_operand & source_operand;
                        bal_pkg::OP_AND_IMM: lr = dest_operand & imm_value;
                        bal_pkg::OP_OR_REG: lr = dest_operand | source_operand;
                        bal_pkg::OP_OR_IMM: lr = dest_operand | imm_value;
                        bal_pkg::OP_SET_BITS: lr = dest_operand | imm_value;
                        bal_pkg::OP_CLEAR_BITS: begin
                            lr = dest_operand & (bal_pkg::ALL_ONES - imm_value);
                        end
                        bal_pkg::OP_TEST_VALUE: lr = dest_operand & dest_operand;
                        bal_pkg::OP_XOR_REG: lr = dest_operand ^ source_operand;
                        bal_pkg::OP_ZERO_REG: lr = dest_operand ^ dest_operand;
                        bal_pkg::OP_INCREMENT, bal_pkg::OP_DECREMENT: begin
                            ar = bal_addsub(dest_operand, 8'h01, 1'b0,
                                            op_code == bal_pkg::OP_DECREMENT);
                            lr = ar[7:0];
                        end
                        default: begin
                            // Unknown opcode: result passes through, no flag changes
                            lr = dest_operand;
                            nxt_st.flags_mask = 8'h00;
                        end
                    endcase
                    nxt_st.res_low = lr;
                    nxt_st.flags_out = bal_logic_flags(lr);
                    if (op_code == bal_pkg::OP_INCREMENT || op_code == bal_pkg::OP_DECREMENT) begin
                        nxt_st.flags_out[bal_pkg::FLAG_V] = ar[9];
                    end
                    if (arith) begin
                        ar = bal_addsub(dest_operand, operand, use_carry & carry, is_sub);
                        nxt_st.res_low = ar[7:0];
                        nxt_st.flags_out = bal_logic_flags(ar[7:0]);
                        nxt_st.flags_out[bal_pkg::FLAG_C] = ar[8];
                        nxt_st.flags_out[bal_pkg::FLAG_V] = ar[9];
                        nxt_st.flags_out[bal_pkg::FLAG_H] = ar[10];
                        nxt_st.flags_mask = bal_pkg::MASK_ARITH;
                    end
                end
            end
            BAL_WORD: begin
                if (wif.done) begin
                    nxt_st.state = BAL_IDLE;
                    nxt_st.busy = 1'b0;
                    nxt_st.res_valid = 1'b1;
                    nxt_st.res_word = 1'b1;
                    nxt_st.res_low = wif.result[7:0];
                    nxt_st.res_high = wif.result[15:8];
                    nxt_st.flags_out = wif.flags;
                    nxt_st.flags_mask = bal_pkg::MASK_WORD;
                end
            end
            default: nxt_st.state = BAL_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{state: BAL_IDLE, flags_out: bal_pkg::FLAGS_RESET, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign busy = st_ff.busy;
    assign res_valid = st_ff.res_valid;
    assign res_word = st_ff.res_word;
    assign res_low = st_ff.res_low;
    assign res_high = st_ff.res_high;
    assign flags_out = st_ff.flags_out;
    assign flags_mask = st_ff.flags_mask;
endmodule : bal_alu

// >>> testbench/bal_alu_checker.sv
// Checker: latency and result relations at the byte ALU ports
module bal_alu_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic op_valid,
    input wire logic [4:0] op_code,
    input wire logic [7:0] dest_operand,
    input wire logic [7:0] source_operand,
    input wire logic [7:0] pair_high,
    input wire logic [7:0] imm_value,
    input wire logic [7:0] flags_in,
    input wire logic busy,
    input wire logic res_valid,
    input wire logic res_word,
    input wire logic [7:0] res_low,
    input wire logic [7:0] res_high,
    input wire logic [7:0] flags_out,
    input wire logic [7:0] flags_mask
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic take = op_valid && !busy;
    wire logic is_word = op_code == bal_pkg::OP_WORD_ADD_IMM
        || op_code == bal_pkg::OP_WORD_SUB_IMM;
    wire logic [15:0] pair = {pair_high, dest_operand};
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence word_walk;
        ##1 busy ##1 busy ##1 (res_valid && res_word && !busy);
    endsequence
    byte_latency_a: assert property (take && !is_word |=> res_valid && !res_word)
        else $error("byte result late");
    word_latency_a: assert property (take && is_word |-> word_walk)
        else $error("word walk broken");
    word_add_a: assert property (take && op_code == bal_pkg::OP_WORD_ADD_IMM |->
        ##3 {res_high, res_low} == $past(pair + imm_value, 3)) else $error("word sum wrong");
    word_sub_a: assert property (take && op_code == bal_pkg::OP_WORD_SUB_IMM |->
        ##3 {res_high, res_low} == $past(pair - imm_value, 3)) else $error("word diff wrong");
    sub_imm_a: assert property (take && op_code == bal_pkg::OP_SUB_IMM |->
        ##1 res_low == $past(dest_operand - imm_value)) else $error("difference wrong");
    sub_carry_a: assert property (take && op_code == bal_pkg::OP_SUB_CARRY_REG |=>
        res_low == $past(dest_operand - source_operand - flags_in[bal_pkg::FLAG_C]))
        else $error("borrow chain wrong");
    clear_bits_a: assert property (take && op_code == bal_pkg::OP_CLEAR_BITS |=>
        res_low == $past(dest_operand & (bal_pkg::ALL_ONES - imm_value)))
        else $error("clear bits wrong");
    logic_mask_a: assert property (take && op_code inside {[5'h08:5'h0F]} |=>
        flags_mask == bal_pkg::MASK_LOGIC && !flags_out[bal_pkg::FLAG_V])
        else $error("logic flags wrong");
    step_carry_a: assert property (take && op_code inside {[5'h11:5'h12]} |=>
        !flags_mask[bal_pkg::FLAG_C] && res_low == $past(dest_operand
        + (op_code == bal_pkg::OP_INCREMENT ? 8'h01 : 8'hFF))) else $error("step wrong");
endmodule // bal_alu_checker

bind bal_alu bal_alu_checker i_chk (.*);

// >>> testbench/bal_core_model.sv
// Decoder and register file model presenting operations to the ALU
module bal_core_model (
    input wire logic clk,
    input wire logic busy,
    output logic op_valid,
    output logic [4:0] op_code,
    output logic [7:0] dest_operand,
    output logic [7:0] source_operand,
    output logic [7:0] pair_high,
    output logic [7:0] imm_value,
    output logic [7:0] flags_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {op_valid, op_code, dest_operand, source_operand, pair_high, imm_value, flags_in} = '0;
    end
    // Waits out a word operation rather than leaning on the ignore-while-busy rule
    task automatic issue(input logic [4:0] op, input logic [7:0] d, s, ph, k, f);
        while (busy !== 1'b0) begin
            op_valid = 1'b0;
            @(posedge clk);
            #1;
        end
        {op_valid, op_code, dest_operand, source_operand, pair_high, imm_value, flags_in} =
            {1'b1, op, d, s, ph, k, f};
        @(posedge clk);
        #1;
    endtask
    // Released operands are inverted so a stale value cannot match by luck
    task automatic release_bus();
        op_valid = 1'b0;
        {dest_operand, source_operand, pair_high, imm_value} =
            ~{dest_operand, source_operand, pair_high, imm_value};
    endtask
endmodule // bal_core_model

// >>> testbench/tb_top.sv
// Self-checking bench comparing the byte ALU with an integer model
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [31:0] e; int due;} bal_exp_t;
    logic clk, rst_n, op_valid, busy, res_valid, res_word;
    logic [4:0] op_code;
    logic [7:0] dest_operand, source_operand, pair_high, imm_value, flags_in;
    logic [7:0] res_low, res_high, flags_out, flags_mask;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [31:0] seed = 32'hB490;
    bal_exp_t exp_q[$];
    bal_alu i_dut (.*);
    bal_core_model i_core (.*);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic chk(string name, logic [15:0] seen, logic [15:0] expv);
        n_tests++;
        if (seen !== expv) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, expv, seen);
        end
    endtask
    function automatic logic [31:0] mdl(logic [4:0] op, int d, int s, int ph, int k, int c);
        int r, b, ci, v, h, cy, sh, n, z;
        logic [7:0] m;
        logic [7:0] f;
        m = bal_pkg::MASK_ARITH;
        case (op)
            bal_pkg::OP_ADD_REG, bal_pkg::OP_ADD_CARRY_REG: begin
                ci = op == bal_pkg::OP_ADD_CARRY_REG ? c : 0;
                r = d + s + ci;
                h = ((d & 32'hF) + (s & 32'hF) + ci) >> 4;
                v = ((d ^ r) & (s ^ r) & 32'h80) != 0;
                cy = r > 32'hFF;
            end
            bal_pkg::OP_WORD_ADD_IMM, bal_pkg::OP_WORD_SUB_IMM: begin
                b = ph * 256 + d;
                r = op == bal_pkg::OP_WORD_ADD_IMM ? b + k : b - k;
                v = op == bal_pkg::OP_WORD_ADD_IMM ? (~b & r & 32'h8000) != 0
                    : (b & ~r & 32'h8000) != 0;
                cy = r < 0 || r > 32'hFFFF;
                m = bal_pkg::MASK_WORD;
            end
            bal_pkg::OP_AND_REG: r = d & s;
            bal_pkg::OP_AND_IMM: r = d & k;
            bal_pkg::OP_OR_REG: r = d | s;
            bal_pkg::OP_OR_IMM, bal_pkg::OP_SET_BITS: r = d | k;
            bal_pkg::OP_XOR_REG: r = d ^ s;
            bal_pkg::OP_CLEAR_BITS: r = d & (32'hFF - k);
            bal_pkg::OP_TEST_VALUE: r = d & d;
            bal_pkg::OP_ZERO_REG: r = d ^ d;
            bal_pkg::OP_INCREMENT, bal_pkg::OP_DECREMENT: begin
                r = op == bal_pkg::OP_INCREMENT ? d + 1 : d - 1;
                v = d == (op == bal_pkg::OP_INCREMENT ? 32'h7F : 32'h80);
            end
            bal_pkg::OP_SUB_REG, bal_pkg::OP_SUB_IMM, bal_pkg::OP_SUB_CARRY_REG,
            bal_pkg::OP_SUB_CARRY_IMM: begin
                b = (op == bal_pkg::OP_SUB_REG || op == bal_pkg::OP_SUB_CARRY_REG) ? s : k;
                ci = op inside {bal_pkg::OP_SUB_CARRY_REG, bal_pkg::OP_SUB_CARRY_IMM} ? c : 0;
                r = d - b - ci;
                // Signed masks: an unsigned nibble difference can never go below zero
                h = (d & 15) - (b & 15) - ci < 0;
                v = ((d ^ b) & (d ^ r) & 32'h80) != 0;
                cy = r < 0;
            end
            default: {r, m} = {d, 8'h00};
        endcase
        if (op inside {[bal_pkg::OP_AND_REG:bal_pkg::OP_DECREMENT]}) m = bal_pkg::MASK_LOGIC;
        sh = m == bal_pkg::MASK_WORD ? 15 : 7;
        r = r & ((1 << (sh + 1)) - 1);
        n = r >> sh;
        z = r == 0;
        f = 8'(cy | z << 1 | n << 2 | v << 3 | (n ^ v) << 4 | h << 5);
        return {m, f, r[15:0]};
    endfunction
    task automatic run(logic [4:0] op, logic [7:0] d, s, ph, k, f);
        i_core.issue(op, d, s, ph, k, f);
        // cyc already counts the take edge, so a byte result shows in that cycle
        exp_q.push_back('{mdl(op, d, s, ph, k, f[bal_pkg::FLAG_C]),
            cyc + (op inside {bal_pkg::OP_WORD_ADD_IMM, bal_pkg::OP_WORD_SUB_IMM} ?
            bal_pkg::WORD_CYCLES : 0)});
    endtask
    always @(negedge clk) begin
        if (rst_n && res_valid === 1'b1) begin
            bal_exp_t e;
            chk("pending", 16'(exp_q.size() != 0), 16'h0001);
            e = exp_q.pop_front();
            chk("latency", 16'(cyc), 16'(e.due));
            chk("result", {res_high, res_low}, e.e[15:0]);
            chk("word", 16'(res_word), 16'(e.e[31:24] == bal_pkg::MASK_WORD));
            chk("mask", 16'(flags_mask), 16'(e.e[31:24]));
            chk("flags", 16'(flags_out & flags_mask), 16'(e.e[23:16] & e.e[31:24]));
        end
    end
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        end_sim();
    end
    initial begin
        rst_n = 1'b0;
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        // Boundary cases first: carry chains, signed overflow, word wrap
        run(bal_pkg::OP_ADD_CARRY_REG, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h01);
        run(bal_pkg::OP_SUB_CARRY_IMM, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01);
        run(bal_pkg::OP_SUB_REG, 8'h80, 8'h01, 8'h00, 8'h00, 8'h00);
        run(bal_pkg::OP_WORD_ADD_IMM, 8'hFF, 8'h00, 8'hFF, 8'h01, 8'h00);
        run(bal_pkg::OP_WORD_SUB_IMM, 8'h00, 8'h00, 8'h80, 8'h01, 8'h00);
        run(bal_pkg::OP_INCREMENT, 8'h7F, 8'h00, 8'h00, 8'h00, 8'h01);
        run(bal_pkg::OP_DECREMENT, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00);
        run(bal_pkg::OP_CLEAR_BITS, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'h00);
        run(bal_pkg::OP_ZERO_REG, 8'h5A, 8'h00, 8'h00, 8'h00, 8'h00);
        run(bal_pkg::OP_TEST_VALUE, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00);
        run(5'h1F, 8'h3C, 8'h00, 8'h00, 8'h00, 8'h00);
        // Every opcode back to back with random operands
        repeat (30) begin
            for (int i = 0; i < 19; i++) begin
                run(5'(i), rnd(), rnd(), rnd(), rnd(), rnd());
            end
        end
        i_core.release_bus();
        repeat (4) @(posedge clk);
        chk("left over", 16'(exp_q.size()), 16'h0000);
        end_sim();
    end
endmodule // tb_top
